// *** core/hap_activation_fsm.sv ***
// Purpose: central-terminal data pump activation state machine with APB status
// Assumes: all inputs synchronous to pclk; sync results arrive per frame
// Notes: long timeouts are parameters so simulation can shorten them
`timescale 1ns/10ps
// Functional notes
// - activating sub-state code reported as 4 bits during Activating
// - step gain status is an 8-bit read-only register at index 6
// - state bits sit at bit 7, bit 6 and bit 3 of step gain
// - digital gain field in bits 5..4, codes mean gain 1, 2, 4, 8
// - analog gain field in bits 2..0, -12 dB upward in 2 dB steps
// - main state coded 000 to 101; 110 and 111 never reported
// - transmit payload reaches the line only in states 010, 011, 100
// - reset gives Inactive; states advance in fixed order
// - pin mode: request pin rising edge starts activation if quiet low
// - register mode: request bit level starts activation if quiet bit 0
// - no sync in 30 s: stop, De-Activated, then Inactive, flag signal loss
// - sync found while Activating: Active-1 and active status bit set
// - sync held until activation timer expiry: advance to Active-2
// - six missed frames set sync loss flag, active goes to Pending
// - sync again within two seconds returns to previous active state
// - loss beyond two seconds sets timer expiry flag, go De-Activated
// - from Pending via De-Activated: one second no signal, Inactive, flag
// - quiet rising edge moves Active-2 straight to De-Activated
// - sub-state code reads 0000 outside Activating
// - sub-state status is a read-only register at index 5
module hap_activation_fsm import hap_pkg::*; #(
  parameter int unsigned DATA_W = 1,
  parameter int unsigned ACT_TMO_CYCLES = ACT_TMO_CYC,
  parameter int unsigned ACT_TMR_CYCLES = ACT_TMR_CYC,
  parameter int unsigned PEND_CYCLES = PEND_CYC,
  parameter int unsigned LOST_CYCLES = LOST_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control pins
  input wire logic activation_request,
  input wire logic quiet,
  // receive side status
  input wire hap_frame_s frame,
  input wire logic remote_signal,
  input wire logic [3:0] activating_substate_code,
  input wire hap_gain_s gain,
  // payload
  input wire logic [DATA_W-1:0] tx_payload,
  output logic [DATA_W-1:0] line_data,
  output logic transmit_on,
  // state view
  output logic [2:0] state_code
);
  typedef struct packed {
    hap_state_e st;
    hap_state_e prev_active;
    logic req_pin_d;
    logic quiet_pin_d;
    logic quiet_bit_d;
    logic [2:0] ctrl;
    logic [3:0] events;
    logic [3:0] sub;
    hap_gain_s gain;
    logic [DATA_W-1:0] line;
    logic tx_on;
    logic [31:0] rdata;
    logic err;
  } hap_top_s;
  hap_top_s st_r, st_nxt;
  logic tmr_start, tmr_stop, tmr_exp, tmr_run;
  logic [TMR_W-1:0] tmr_load;
  logic sync_found, sync_lost, sync_clear;
  logic setup_ph, wr_acc, start_req, quiet_rise;
  logic [7:0] step_gain_val;
  logic [2:0] cur_code;
  if (DATA_W < 1 || ACT_TMO_CYCLES < 2 || ACT_TMR_CYCLES < 2
      || PEND_CYCLES < 2 || LOST_CYCLES < 2) begin : g_chk
    $error("unsupported parameter value");
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  hap_sec_timer #(
    .W(TMR_W)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmr_start),
    .stop(tmr_stop),
    .load(tmr_load),
    .expired(tmr_exp),
    .running(tmr_run)
  );
  hap_sync_monitor #(
    .FIND_N(SYNC_FIND_N),
    .LOSS_N(SYNC_LOSS_N)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .frame(frame),
    .clear(sync_clear),
    .found(sync_found),
    .lost(sync_lost)
  );
  // ---------------------------------------------------------------
  // request and quiet decode
  // ---------------------------------------------------------------
  always_comb begin
    if (st_r.ctrl[CTRL_REGMODE]) begin
      start_req = st_r.ctrl[CTRL_ACTIVATION_REQUEST] && !st_r.ctrl[CTRL_QUIET];
      quiet_rise = st_r.ctrl[CTRL_QUIET] && !st_r.quiet_bit_d;
    end else begin
      start_req = activation_request && !st_r.req_pin_d && !quiet;
      quiet_rise = quiet && !st_r.quiet_pin_d;
    end
  end
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign sync_clear = (st_r.st == S_INACTIVE) || (st_r.st == S_DEACT);
  // status word: state bits 7, 6, 3 around gain fields
  assign cur_code = st_code(st_r.st);
  assign step_gain_val = {cur_code[2], cur_code[1], st_r.gain.digital_gain_field,
                          cur_code[0], st_r.gain.analog_gain_field};
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    tmr_load = TMR_W'(ACT_TMO_CYCLES);
    st_nxt.req_pin_d = activation_request;
    st_nxt.quiet_pin_d = quiet;
    st_nxt.quiet_bit_d = st_r.ctrl[CTRL_QUIET];
    st_nxt.gain = gain;
    case (st_r.st)
      S_INACTIVE: begin
        if (start_req) begin
          st_nxt.st = S_ACTIVATING;
          tmr_start = 1'b1;
          tmr_load = TMR_W'(ACT_TMO_CYCLES);
        end
      end
      S_ACTIVATING: begin
        if (sync_found) begin
          st_nxt.st = S_ACTIVE1;
          st_nxt.events[EV_ACTIVE] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TMR_W'(ACT_TMR_CYCLES);
        end else if (tmr_exp) begin
          st_nxt.st = S_DEACT;
          st_nxt.events[EV_LOST] = 1'b1;
        end
      end
      S_ACTIVE1: begin
        if (sync_lost) begin
          st_nxt.st = S_PEND;
          st_nxt.prev_active = S_ACTIVE1;
          st_nxt.events[EV_SWL] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TMR_W'(PEND_CYCLES);
        end else if (tmr_exp) begin
          st_nxt.st = S_ACTIVE2;
          tmr_stop = 1'b1;
        end
      end
      S_ACTIVE2: begin
        if (quiet_rise) begin
          st_nxt.st = S_DEACT;
          tmr_start = 1'b1;
          tmr_load = TMR_W'(LOST_CYCLES);
        end else if (sync_lost) begin
          st_nxt.st = S_PEND;
          st_nxt.prev_active = S_ACTIVE2;
          st_nxt.events[EV_SWL] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TMR_W'(PEND_CYCLES);
        end
      end
      S_PEND: begin
        if (sync_found) begin
          st_nxt.st = st_r.prev_active;
          tmr_stop = (st_r.prev_active == S_ACTIVE2);
          tmr_start = (st_r.prev_active == S_ACTIVE1);
          tmr_load = TMR_W'(ACT_TMR_CYCLES);
        end else if (tmr_exp) begin
          st_nxt.st = S_DEACT;
          st_nxt.events[EV_SWLT] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TMR_W'(LOST_CYCLES);
        end
      end
      S_DEACT: begin
        if (!tmr_run && !tmr_exp) begin
          st_nxt.st = S_INACTIVE;
        end else if (remote_signal) begin
          tmr_start = 1'b1;
          tmr_load = TMR_W'(LOST_CYCLES);
        end else if (tmr_exp) begin
          st_nxt.st = S_INACTIVE;
          st_nxt.events[EV_LOST] = 1'b1;
        end
      end
      default: begin
        st_nxt.st = S_INACTIVE;
        tmr_stop = 1'b1;
      end
    endcase
    // sub-state only visible while activating
    st_nxt.sub = (st_nxt.st == S_ACTIVATING) ? activating_substate_code
                                              : SUB_NONE;
    // payload gate
    st_nxt.tx_on = (st_nxt.st == S_ACTIVE1) || (st_nxt.st == S_ACTIVE2)
                   || (st_nxt.st == S_PEND);
    st_nxt.line = st_nxt.tx_on ? tx_payload : '0;
    // ---------------------------------------------------------------
    // apb access
    // ---------------------------------------------------------------
    if (wr_acc && paddr == reg_addr(IDX_CTRL)) begin
      st_nxt.ctrl = pwdata[2:0];
    end
    if (wr_acc && paddr == reg_addr(IDX_EVENT)) begin
      // set wins over write-one-to-clear only for a bit that was clear before
      st_nxt.events = (st_r.events & ~pwdata[3:0]) | (st_nxt.events & ~st_r.events);
    end
    if (setup_ph) begin
      st_nxt.err = 1'b0;
      case (paddr)
        reg_addr(IDX_SUBSTATE): st_nxt.rdata = {28'h0000000, st_r.sub};
        reg_addr(IDX_STEP_GAIN): st_nxt.rdata = {24'h000000, step_gain_val};
        reg_addr(IDX_CTRL): st_nxt.rdata = {29'h0, st_r.ctrl};
        reg_addr(IDX_EVENT): st_nxt.rdata = {28'h0000000, st_r.events};
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.err = 1'b1;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.st <= S_INACTIVE;
      st_r.prev_active <= S_ACTIVE1;
      st_r.req_pin_d <= 1'b0;
      st_r.quiet_pin_d <= 1'b0;
      st_r.quiet_bit_d <= 1'b0;
      st_r.ctrl <= CTRL_RST;
      st_r.events <= EV_RST;
      st_r.sub <= SUB_NONE;
      st_r.gain <= '0;
      st_r.line <= '0;
      st_r.tx_on <= 1'b0;
      st_r.rdata <= 32'h00000000;
      st_r.err <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = st_r.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && st_r.err;
  assign line_data = st_r.line;
  assign transmit_on = st_r.tx_on;
  assign state_code = st_code(st_r.st);
endmodule // hap_activation_fsm

// *** inc/hap_pkg.sv ***
// Purpose: shared constants, types and helpers of the activation state machine
// Assumes: 25 MHz pclk, registers reached over APB with 32-bit data
// Notes: timing counts derive from seconds and the clock rate
package hap_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned ACT_TMO_S = 30;
  localparam int unsigned ACT_TMR_S = 30;
  localparam int unsigned PEND_S = 2;
  localparam int unsigned LOST_S = 1;
  localparam int unsigned ACT_TMO_CYC = ACT_TMO_S * CLK_HZ;
  localparam int unsigned ACT_TMR_CYC = ACT_TMR_S * CLK_HZ;
  localparam int unsigned PEND_CYC = PEND_S * CLK_HZ;
  localparam int unsigned LOST_CYC = LOST_S * CLK_HZ;
  localparam int unsigned TMR_W = 32;
  localparam int unsigned SYNC_FIND_N = 2;
  localparam int unsigned SYNC_LOSS_N = 6;
  // ---------------------------------------------------------------
  // register map: index, byte address is four times the index
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [3:0] IDX_SUBSTATE = 4'h5;
  localparam logic [3:0] IDX_STEP_GAIN = 4'h6;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  localparam logic [3:0] IDX_EVENT = 4'h9;
  localparam int unsigned ST_HI_BIT = 7;
  localparam int unsigned ST_MID_BIT = 6;
  localparam int unsigned DG_LSB = 4;
  localparam int unsigned ST_LO_BIT = 3;
  localparam int unsigned AG_LSB = 0;
  localparam int unsigned CTRL_ACTIVATION_REQUEST = 0;
  localparam int unsigned CTRL_QUIET = 1;
  localparam int unsigned CTRL_REGMODE = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int unsigned EV_ACTIVE = 0;
  localparam int unsigned EV_SWL = 1;
  localparam int unsigned EV_SWLT = 2;
  localparam int unsigned EV_LOST = 3;
  localparam logic [3:0] EV_RST = 4'h0;
  // ---------------------------------------------------------------
  // state codes
  // ---------------------------------------------------------------
  localparam logic [2:0] ST_INACTIVE = 3'h0;
  localparam logic [2:0] ST_ACTIVATING = 3'h1;
  localparam logic [2:0] ST_ACTIVE1 = 3'h2;
  localparam logic [2:0] ST_ACTIVE2 = 3'h3;
  localparam logic [2:0] ST_PEND = 3'h4;
  localparam logic [2:0] ST_DEACT = 3'h5;
  localparam logic [3:0] SUB_NONE = 4'h0;
  typedef enum logic [2:0] {
    S_INACTIVE, S_ACTIVATING, S_ACTIVE1, S_ACTIVE2, S_PEND, S_DEACT
  } hap_state_e;
  typedef struct packed {
    logic [1:0] digital_gain_field;
    logic [2:0] analog_gain_field;
  } hap_gain_s;
  typedef struct packed {
    logic frame_strobe;
    logic sync_match;
  } hap_frame_s;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] st_code(input hap_state_e s);
    case (s)
      S_INACTIVE: st_code = ST_INACTIVE;
      S_ACTIVATING: st_code = ST_ACTIVATING;
      S_ACTIVE1: st_code = ST_ACTIVE1;
      S_ACTIVE2: st_code = ST_ACTIVE2;
      S_PEND: st_code = ST_PEND;
      S_DEACT: st_code = ST_DEACT;
      default: st_code = ST_INACTIVE;
    endcase
  endfunction
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [3:0] idx);
    reg_addr = {{(ADDR_W-6){1'b0}}, idx, 2'b00};
  endfunction
endpackage

// *** core/hap_sec_timer.sv ***
// Purpose: loadable down-counter that pulses once at expiry
// Assumes: start and stop come from the state machine; start repeats each cycle in De-Activated while remote_signal is high
// Notes: start wins over stop
`timescale 1ns/10ps
module hap_sec_timer import hap_pkg::*; #(
  parameter int unsigned W = TMR_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load,
  // status
  output logic expired,
  output logic running
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic exp;
  } hap_tmr_s;
  hap_tmr_s st_r, st_nxt;
  if (W < 2) begin : g_chk
    $error("timer width too small");
  end
  // ---------------------------------------------------------------
  // count down
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.exp = 1'b0;
    if (start) begin
      st_nxt.cnt = load - {{(W-1){1'b0}}, 1'b1};
      st_nxt.run = 1'b1;
    end else if (stop) begin
      st_nxt.run = 1'b0;
    end else if (st_r.run) begin
      if (st_r.cnt == '0) begin
        st_nxt.run = 1'b0;
        st_nxt.exp = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign expired = st_r.exp;
  assign running = st_r.run;
endmodule // hap_sec_timer

// *** core/hap_sync_monitor.sv ***
// Purpose: frame sync word match and loss detection
// Assumes: one frame_strobe per received frame with its match result
// Notes: clear forces out of sync
`timescale 1ns/10ps
module hap_sync_monitor import hap_pkg::*; #(
  parameter int unsigned FIND_N = SYNC_FIND_N,
  parameter int unsigned LOSS_N = SYNC_LOSS_N
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frames
  input wire hap_frame_s frame,
  input wire logic clear,
  // results
  output logic found,
  output logic lost
);
  typedef struct packed {
    logic [3:0] hit;
    logic [3:0] miss;
    logic in_sync;
    logic found;
    logic lost;
  } hap_sync_s;
  hap_sync_s st_r, st_nxt;
  if (FIND_N < 1 || FIND_N > 15 || LOSS_N < 1 || LOSS_N > 15) begin : g_chk
    $error("sync counts out of range");
  end
  // ---------------------------------------------------------------
  // consecutive match and miss counting
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.found = 1'b0;
    st_nxt.lost = 1'b0;
    if (clear) begin
      st_nxt = '0;
    end else if (frame.frame_strobe) begin
      if (frame.sync_match) begin
        st_nxt.miss = '0;
        st_nxt.hit = st_r.hit + 4'h1;
        if (!st_r.in_sync && st_r.hit == 4'(FIND_N - 1)) begin
          st_nxt.in_sync = 1'b1;
          st_nxt.found = 1'b1;
          st_nxt.hit = '0;
        end
      end else begin
        st_nxt.hit = '0;
        st_nxt.miss = st_r.miss + 4'h1;
        if (st_r.in_sync && st_r.miss == 4'(LOSS_N - 1)) begin
          st_nxt.in_sync = 1'b0;
          st_nxt.lost = 1'b1;
          st_nxt.miss = '0;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign found = st_r.found;
  assign lost = st_r.lost;
endmodule // hap_sync_monitor

// *** dv/hap_activation_fsm_properties.sv ***
// Purpose: port checks of the activation state machine
// Assumes: parameters equal those of the bound instance
// Notes: state dwell counted in helper logic
`timescale 1ns/10ps
module hap_activation_fsm_properties import hap_pkg::*; #(
  parameter int unsigned DATA_W = 1,
  parameter int unsigned ACT_TMO_CYCLES = ACT_TMO_CYC,
  parameter int unsigned ACT_TMR_CYCLES = ACT_TMR_CYC,
  parameter int unsigned PEND_CYCLES = PEND_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // payload and state
  input wire logic [DATA_W-1:0] tx_payload,
  input wire logic [DATA_W-1:0] line_data,
  input wire logic transmit_on,
  input wire logic [2:0] state_code
);
  // ---------------------------------------------------------------
  // dwell counter and checks
  // ---------------------------------------------------------------
  logic [31:0] stay_r;
  logic [2:0] prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stay_r <= 32'h0;
      prev_r <= ST_INACTIVE;
    end else begin
      stay_r <= (state_code != prev_r) ? 32'h0 : stay_r + 32'h1;
      prev_r <= state_code;
    end
  end
  function automatic logic step_ok(input logic [5:0] t);
    return t inside {6'h01, 6'h0a, 6'h0d, 6'h13, 6'h14, 6'h1c, 6'h1d, 6'h22, 6'h23, 6'h25, 6'h28};
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_timeout;
    state_code == ST_ACTIVATING ##1 state_code == ST_DEACT;
  endsequence
  sequence s_step_read;
    psel && penable && !pwrite && paddr == 12'h018;
  endsequence
  a_state_legal: assert property (state_code < 3'h6)
    else $error("illegal state code");
  a_state_order: assert property (state_code != $past(state_code) |->
    step_ok({$past(state_code), state_code})) else $error("bad state step");
  a_tx_window: assert property (transmit_on == (state_code inside {3'h2, 3'h3, 3'h4}))
    else $error("transmit window wrong");
  a_line_pass: assert property (line_data == (transmit_on ? $past(tx_payload) : '0))
    else $error("line data wrong");
  a_timeout_exit: assert property (s_timeout |=> state_code == ST_INACTIVE)
    else $error("no return to inactive");
  a_activating_dwell: assert property (state_code == ST_ACTIVATING |->
    stay_r <= 32'(ACT_TMO_CYCLES + 8)) else $error("activating too long");
  a_active1_dwell: assert property (state_code == ST_ACTIVE1 |->
    stay_r <= 32'(ACT_TMR_CYCLES + 8)) else $error("active1 too long");
  a_pend_dwell: assert property (state_code == ST_PEND |->
    stay_r <= 32'(PEND_CYCLES + 8)) else $error("pending too long");
  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready wrong");
  a_step_fields: assert property (s_step_read |-> prdata[31:8] == 24'h0 &&
    {prdata[7], prdata[6], prdata[3]} < 3'h6) else $error("step word wrong");
  a_substate_idle: assert property (psel && penable && !pwrite && paddr == 12'h014 &&
    $past(state_code) != ST_ACTIVATING && $past(state_code, 2) != ST_ACTIVATING |->
    prdata == 32'h0) else $error("substate not zero");
  a_mapped_ok: assert property (psel && penable && paddr inside {12'h014, 12'h018} |->
    !pslverr) else $error("mapped read refused");
endmodule // hap_activation_fsm_properties
bind hap_activation_fsm hap_activation_fsm_properties #(
  .DATA_W(DATA_W), .ACT_TMO_CYCLES(ACT_TMO_CYCLES),
  .ACT_TMR_CYCLES(ACT_TMR_CYCLES), .PEND_CYCLES(PEND_CYCLES)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_payload(tx_payload), .line_data(line_data), .transmit_on(transmit_on),
  .state_code(state_code)
);

// *** dv/hap_remote_model.sv ***
// Purpose: remote transceiver, frames with or without sync word
// Assumes: mode 0 silent, 1 matching frames, 2 frames without match
// Notes: match line toggles between strobes
`timescale 1ns/10ps
module hap_remote_model import hap_pkg::*; #(
  parameter int unsigned FRAME_CYC = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // scenario
  input wire logic [1:0] mode,
  // line side
  output hap_frame_s frame,
  output logic remote_signal
);
  int unsigned cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      frame <= '0;
      remote_signal <= 1'b0;
    end else begin
      cnt <= (cnt + 1) % FRAME_CYC;
      frame.frame_strobe <= (mode != 2'h0) && (cnt == 0);
      frame.sync_match <= (mode != 2'h0 && cnt == 0) ? (mode == 2'h1) : ~frame.sync_match;
      remote_signal <= (mode != 2'h0);
    end
  end
endmodule // hap_remote_model

// *** dv/hap_activation_fsm_test.sv ***
// Purpose: self-checking bench of the activation state machine
// Assumes: shortened timers, remote model makes the frames
// Notes: apb master holds each request until pready
`timescale 1ns/10ps
module hap_activation_fsm_test import hap_pkg::*; ;
  localparam int TMO = 200;
  localparam int TMR = 150;
  localparam int PND = 100;
  localparam int LST = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic activation_request, quiet, remote_signal, transmit_on;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] sub;
  logic [2:0] state_code;
  logic [1:0] mode;
  logic [0:0] tx_payload, line_data, tx_prev;
  hap_frame_s frame;
  hap_gain_s gain;
  int fails, num_checks, off;
  logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'h8};
  hap_activation_fsm #(.ACT_TMO_CYCLES(TMO), .ACT_TMR_CYCLES(TMR), .PEND_CYCLES(PND),
    .LOST_CYCLES(LST)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .activation_request(activation_request), .quiet(quiet),
    .frame(frame), .remote_signal(remote_signal), .activating_substate_code(sub),
    .gain(gain), .tx_payload(tx_payload), .line_data(line_data),
    .transmit_on(transmit_on), .state_code(state_code));
  hap_remote_model u_remote (.pclk(pclk), .presetn(presetn), .mode(mode), .frame(frame),
    .remote_signal(remote_signal));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tx_prev <= tx_payload;
    tx_payload <= 1'($urandom);
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    num_checks++;
    if (y !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_st(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    while (state_code !== s && n < lim) begin
      n++;
      @(posedge pclk);
    end
    chk("state_code", 32'(s), 32'(state_code));
  endtask
  function automatic logic [31:0] step_word(input logic [2:0] s, input hap_gain_s g);
    return {24'h0, s[2], s[1], g.digital_gain_field, s[0], g.analog_gain_field};
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test();
  end
  initial begin
    void'($urandom(73));
    {presetn, psel, penable, pwrite, activation_request, quiet} = 6'h0;
    {paddr, pwdata, sub, mode, fails, num_checks} = '0;
    gain = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      gain <= '{digital_gain_field: 2'(i >> 2), analog_gain_field: 3'(i)};
      apb(12'h018, 1'b1, 32'hff);
      apb(12'h018, 1'b0, 32'h0);
      chk("step_gain", step_word(ST_INACTIVE, gain), r);
      apb(12'h014, 1'b0, 32'h0);
      chk("substate", 32'h0, r);
    end
    apb(12'h030, 1'b0, 32'h0);
    chk("unmapped", 32'h1, 32'(e));
    $display("test registers done");
    quiet <= 1'b1;
    activation_request <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("state_code", 32'(ST_INACTIVE), 32'(state_code));
    activation_request <= 1'b0;
    quiet <= 1'b0;
    @(posedge pclk);
    activation_request <= 1'b1;
    wait_st(ST_ACTIVATING, 8);
    off = $urandom % 8;
    for (int k = 0; k < 8; k++) begin
      sub <= codes[(k + off) % 8];
      apb(12'h014, 1'b0, 32'h0);
      chk("substate", 32'(codes[(k + off) % 8]), r);
    end
    activation_request <= 1'b0;
    mode <= 2'h1;
    wait_st(ST_ACTIVE1, 40);
    for (int k = 0; k < 2; k++) begin
      apb(12'h024, 1'b0, 32'h0);
      chk("ev_active", 32'h1, 32'(r[EV_ACTIVE]));
    end
    apb(12'h024, 1'b1, 32'hf);
    wait_st(ST_ACTIVE2, TMR + 20);
    chk("transmit_on", 32'h1, 32'(transmit_on));
    chk("line_data", 32'(tx_prev), 32'(line_data));
    mode <= 2'h2;
    wait_st(ST_PEND, 60);
    apb(12'h024, 1'b0, 32'h0);
    chk("ev_swl", 32'h1, 32'(r[EV_SWL]));
    mode <= 2'h1;
    wait_st(ST_ACTIVE2, 30);
    mode <= 2'h2;
    wait_st(ST_PEND, 60);
    wait_st(ST_DEACT, PND + 20);
    apb(12'h024, 1'b0, 32'h0);
    chk("ev_swlt", 32'h1, 32'(r[EV_SWLT]));
    mode <= 2'h0;
    wait_st(ST_INACTIVE, LST + 30);
    apb(12'h024, 1'b0, 32'h0);
    chk("ev_lost", 32'h1, 32'(r[EV_LOST]));
    chk("transmit_on", 32'h0, 32'(transmit_on));
    chk("line_data", 32'h0, 32'(line_data));
    apb(12'h024, 1'b1, 32'hf);
    repeat (20) @(posedge pclk);
    $display("test pin activation done");
    apb(12'h020, 1'b1, 32'h5);
    wait_st(ST_ACTIVATING, 8);
    apb(12'h020, 1'b1, 32'h4);
    wait_st(ST_DEACT, TMO + 20);
    wait_st(ST_INACTIVE, 2);
    apb(12'h024, 1'b0, 32'h0);
    chk("ev_lost", 32'h1, 32'(r[EV_LOST]));
    apb(12'h024, 1'b1, 32'hf);
    repeat (32) @(posedge pclk);
    $display("test timeout done");
    apb(12'h020, 1'b1, 32'h5);
    mode <= 2'h1;
    apb(12'h020, 1'b1, 32'h4);
    wait_st(ST_ACTIVE2, TMR + 60);
    apb(12'h020, 1'b1, 32'h6);
    wait_st(ST_DEACT, 4);
    mode <= 2'h0;
    wait_st(ST_INACTIVE, LST + 30);
    apb(12'h020, 1'b1, 32'h7);
    repeat (6) @(posedge pclk);
    chk("state_code", 32'(ST_INACTIVE), 32'(state_code));
    $display("test quiet exit done");
    finish_test();
  end
endmodule // hap_activation_fsm_test
